// File: hw/spim_params.svh
// Purpose: Constants of the serial port interrupt mask block.
// Assumes: Register offsets are byte addresses of aligned 32-bit words.
// Notes:   Bit positions are shared by status, enable, disable and mask words.
`ifndef SPIM_PARAMS_SVH
`define SPIM_PARAMS_SVH

// Register byte offsets
`define SPIM_OFS_STATUS   8'h00
`define SPIM_OFS_IRQ_EN   8'h04
`define SPIM_OFS_IRQ_DIS  8'h08
`define SPIM_OFS_IRQ_MASK 8'h0c

// Number of interrupt sources and of sticky event flags
`define SPIM_NSRC    12
`define SPIM_NSTICKY 5

// Source bit positions
`define SPIM_BIT_TX_HOLDING_FREE    0
`define SPIM_BIT_TX_ALL_SENT        1
`define SPIM_BIT_TX_TRANSFER_END    2
`define SPIM_BIT_TX_BUFFERS_DRAINED 3
`define SPIM_BIT_RX_WORD_AVAILABLE  4
`define SPIM_BIT_RX_OVERRUN_FLAG    5
`define SPIM_BIT_RX_TRANSFER_END    6
`define SPIM_BIT_RX_BUFFERS_FULL    7
`define SPIM_BIT_COMPARE_ZERO_HIT   8
`define SPIM_BIT_COMPARE_ONE_HIT    9
`define SPIM_BIT_TX_SYNC_EVENT      10
`define SPIM_BIT_RX_SYNC_EVENT      11

// Sticky flag slots inside the sticky bank
`define SPIM_STK_OVERRUN 0
`define SPIM_STK_CMP0    1
`define SPIM_STK_CMP1    2
`define SPIM_STK_TX_SYNC_EVENT   3
`define SPIM_STK_RX_SYNC_EVENT   4

// Reset values
`define SPIM_MASK_RESET   12'h000
`define SPIM_RDATA_RESET  32'h0000_0000

`endif

// File: hw/spim_pkg.sv
// Purpose: Types of the serial port interrupt mask block.
// Assumes: Constants live in spim_params.svh.
// Notes:   Bus state is a one-bit Gray sequence idle -> respond.
package spim_pkg;

    // Avalon slave handshake state
    typedef enum logic [0:0] {
        SPIM_ST_IDLE = 1'b0,
        SPIM_ST_RESP = 1'b1
    } spim_bus_state_type;

    // Avalon response codes
    typedef enum logic [1:0] {
        SPIM_RSP_OKAY   = 2'b00,
        SPIM_RSP_DECERR = 2'b11
    } spim_resp_type;

    // One bit per interrupt source
    typedef logic [11:0] spim_src_vec_type;

endpackage

// File: hw/spim_sticky_bank.sv
// Purpose: Bank of event flags that latch on a pulse and clear on a read.
// Assumes: Set and clear pulses come from logic on the same clock.
// Notes:   A set in the clearing cycle wins, so no event is lost.
module spim_sticky_bank #(
    parameter int W = 5
) (
    // Clock and reset
    input  wire logic         clock_i,
    input  wire logic         nrst_i,
    // Events and clear
    input  wire logic [W-1:0] set_i,
    input  wire logic         clr_i,
    // Latched flags
    output logic      [W-1:0] flags_o
);

    // One flop per flag; set has priority over the read clear
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_flag
            always_ff @(posedge clock_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    flags_o[gi] <= 1'b0;
                end else if (set_i[gi]) begin
                    flags_o[gi] <= 1'b1;
                end else if (clr_i) begin
                    flags_o[gi] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule

// File: hw/spim_irq_mask.sv
// Purpose: Interrupt enable, disable and mask logic of a sync serial port.
// Assumes: Event inputs come from controller logic on clock_i.
// Notes:   Avalon-MM slave with waitrequest; one wait cycle per access.
//
// Behaviour
// - Enable write ones set mask bits
// - Disable write ones clear mask bits
// - Mask read shows enabled sources as one
// - Bits 0-3 are transmit sources
// - Bits 4-7 are receive sources
// - Bits 8-11 compares and syncs, above unused
// - Disable sync positions really disable syncs
// - Mask register is read-only
// - Command registers are write-only, no state
// - Compare and sync flags latch until status read
// - Receive ready follows holding register occupancy
// - Transmit empty only after shifter finishes
`include "spim_params.svh"

module spim_irq_mask
    import spim_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic              clock_i,
    input  wire logic              nrst_i,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output logic      [31:0]       avs_readdata_o,
    output logic                   avs_waitrequest_o,
    output logic      [1:0]        avs_response_o,
    // Transmit side of the controller
    input  wire logic              tx_holding_free_i,
    input  wire logic              tx_shifter_busy_i,
    input  wire logic              tx_transfer_end_i,
    input  wire logic              tx_buffers_drained_i,
    input  wire logic              tx_sync_event_i,
    // Receive side of the controller
    input  wire logic              rx_word_load_i,
    input  wire logic              rx_holding_read_i,
    input  wire logic              rx_transfer_end_i,
    input  wire logic              rx_buffers_full_i,
    input  wire logic              rx_sync_event_i,
    // Compare units
    input  wire logic              compare_zero_hit_i,
    input  wire logic              compare_one_hit_i,
    // Interrupt line
    output logic                   irq_o
);

    spim_bus_state_type            state_r;
    spim_src_vec_type              mask_r;
    spim_src_vec_type              status_w;
    spim_src_vec_type              set_vec;
    spim_src_vec_type              clr_vec;
    logic [31:0]                   be_bits;
    logic [31:0]                   wdata_eff;
    logic [`SPIM_NSTICKY-1:0]      stk_set;
    logic [`SPIM_NSTICKY-1:0]      stk_flags;
    logic                          hit_status;
    logic                          hit_en;
    logic                          hit_dis;
    logic                          hit_mask;
    logic                          hit_any;
    logic                          accept;
    logic                          commit_wr;
    logic                          status_rd_clr;
    logic                          tx_all_sent_r;
    logic                          rx_word_avail_r;

    // Reset image of the mask as a named constant, so each bit can be picked
    localparam spim_src_vec_type MASK_RST = `SPIM_MASK_RESET;

    // Address decode on full byte offsets
    always_comb begin
        hit_status = (avs_address_i == ADDR_W'(`SPIM_OFS_STATUS));
        hit_en     = (avs_address_i == ADDR_W'(`SPIM_OFS_IRQ_EN));
        hit_dis    = (avs_address_i == ADDR_W'(`SPIM_OFS_IRQ_DIS));
        hit_mask   = (avs_address_i == ADDR_W'(`SPIM_OFS_IRQ_MASK));
        hit_any    = hit_status | hit_en | hit_dis | hit_mask;
    end

    // A request is taken in idle; a write lands when waitrequest is seen low
    assign accept    = (state_r == SPIM_ST_IDLE) & (avs_read_i | avs_write_i);
    assign commit_wr = (state_r == SPIM_ST_RESP) & avs_write_i;

    // Reading status clears the read-sensitive flags at the capture edge,
    // so anything arriving later stays set for the next read
    assign status_rd_clr = accept & avs_read_i & hit_status;

    // Byte lanes gate the write data
    assign be_bits = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                      {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    assign wdata_eff = avs_writedata_i & be_bits;

    // Command decode: only the low source bits act, upper bits ignored
    always_comb begin
        set_vec = '0;
        clr_vec = '0;
        if (commit_wr && hit_en) begin
            set_vec = wdata_eff[`SPIM_NSRC-1:0];
        end
        if (commit_wr && hit_dis) begin
            clr_vec = wdata_eff[`SPIM_NSRC-1:0];
        end
    end

    // Bus handshake: one cycle of waitrequest, then the answer
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r           <= SPIM_ST_IDLE;
            avs_waitrequest_o <= 1'b1;
        end else begin
            case (state_r)
                SPIM_ST_IDLE: begin
                    if (accept) begin
                        state_r           <= SPIM_ST_RESP;
                        avs_waitrequest_o <= 1'b0;
                    end
                end
                SPIM_ST_RESP: begin
                    state_r           <= SPIM_ST_IDLE;
                    avs_waitrequest_o <= 1'b1;
                end
                default: begin
                    state_r           <= SPIM_ST_IDLE;
                    avs_waitrequest_o <= 1'b1;
                end
            endcase
        end
    end

    // Read data and response are captured when the request is taken
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            avs_readdata_o <= `SPIM_RDATA_RESET;
            avs_response_o <= SPIM_RSP_OKAY;
        end else if (accept) begin
            avs_response_o <= hit_any ? SPIM_RSP_OKAY : SPIM_RSP_DECERR;
            if (avs_read_i && hit_status) begin
                avs_readdata_o <= {20'h0_0000, status_w};
            end else if (avs_read_i && hit_mask) begin
                avs_readdata_o <= {20'h0_0000, mask_r};
            end else begin
                // Command words keep no state and read as zero
                avs_readdata_o <= `SPIM_RDATA_RESET;
            end
        end
    end

    // Mask bits; only the command registers reach them, never a direct write
    genvar gi;
    generate
        for (gi = 0; gi < `SPIM_NSRC; gi++) begin : g_mask
            always_ff @(posedge clock_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    mask_r[gi] <= MASK_RST[gi];
                end else if (set_vec[gi]) begin
                    mask_r[gi] <= 1'b1;
                end else if (clr_vec[gi]) begin
                    mask_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Transmit empty needs both the holding word moved and the shifter idle
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_all_sent_r <= 1'b0;
        end else begin
            tx_all_sent_r <= tx_holding_free_i & ~tx_shifter_busy_i;
        end
    end

    // Receive ready tracks the holding register; a new load wins over a read
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_word_avail_r <= 1'b0;
        end else if (rx_word_load_i) begin
            rx_word_avail_r <= 1'b1;
        end else if (rx_holding_read_i) begin
            rx_word_avail_r <= 1'b0;
        end
    end

    // Events that latch until the status register is read
    always_comb begin
        stk_set = '0;
        // Overrun: a load while the previous word is still unread
        stk_set[`SPIM_STK_OVERRUN] = rx_word_load_i & rx_word_avail_r &
                                     ~rx_holding_read_i;
        stk_set[`SPIM_STK_CMP0]    = compare_zero_hit_i;
        stk_set[`SPIM_STK_CMP1]    = compare_one_hit_i;
        stk_set[`SPIM_STK_TX_SYNC_EVENT]   = tx_sync_event_i;
        stk_set[`SPIM_STK_RX_SYNC_EVENT]   = rx_sync_event_i;
    end

    spim_sticky_bank #(
        .W       (`SPIM_NSTICKY)
    ) u_sticky (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .set_i   (stk_set),
        .clr_i   (status_rd_clr),
        .flags_o (stk_flags)
    );

    // Status word; positions match the enable, disable and mask words
    always_comb begin
        status_w = '0;
        status_w[`SPIM_BIT_TX_HOLDING_FREE]    = tx_holding_free_i;
        status_w[`SPIM_BIT_TX_ALL_SENT]        = tx_all_sent_r;
        status_w[`SPIM_BIT_TX_TRANSFER_END]    = tx_transfer_end_i;
        status_w[`SPIM_BIT_TX_BUFFERS_DRAINED] = tx_buffers_drained_i;
        status_w[`SPIM_BIT_RX_WORD_AVAILABLE]  = rx_word_avail_r;
        status_w[`SPIM_BIT_RX_OVERRUN_FLAG]    = stk_flags[`SPIM_STK_OVERRUN];
        status_w[`SPIM_BIT_RX_TRANSFER_END]    = rx_transfer_end_i;
        status_w[`SPIM_BIT_RX_BUFFERS_FULL]    = rx_buffers_full_i;
        status_w[`SPIM_BIT_COMPARE_ZERO_HIT]   = stk_flags[`SPIM_STK_CMP0];
        status_w[`SPIM_BIT_COMPARE_ONE_HIT]    = stk_flags[`SPIM_STK_CMP1];
        status_w[`SPIM_BIT_TX_SYNC_EVENT]      = stk_flags[`SPIM_STK_TX_SYNC_EVENT];
        status_w[`SPIM_BIT_RX_SYNC_EVENT]      = stk_flags[`SPIM_STK_RX_SYNC_EVENT];
    end

    // Interrupt line is registered, so it trails the flags by one cycle;
    // this keeps the output glitch free at the cost of that cycle
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_w & mask_r);
        end
    end

endmodule

// File: sim/spim_irq_mask_checker.sv
// Purpose: Port assertions of the serial port interrupt mask block.
// Assumes: A shadow mask follows every accepted enable or disable write.
// Notes:   Status flags are hidden, so irq checks key on event inputs.
module spim_irq_mask_checker
    import spim_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Watched ports
    input wire logic              clock_i,
    input wire logic              nrst_i,
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic              avs_read_i,
    input wire logic              avs_write_i,
    input wire logic [31:0]       avs_writedata_i,
    input wire logic [3:0]        avs_byteenable_i,
    input wire logic [31:0]       avs_readdata_o,
    input wire logic              avs_waitrequest_o,
    input wire logic [1:0]        avs_response_o,
    input wire logic              tx_shifter_busy_i,
    input wire logic              compare_zero_hit_i,
    input wire logic              irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    spim_src_vec_type shadow_r;
    logic             done;
    logic [11:0]      lanes;
    // Accepted transfer; disabled byte lanes write as zero
    assign done  = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
    assign lanes = {{4{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    // Shadow mask, moved on the edge that completes the write
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            shadow_r <= 12'h000;
        end else if (done && avs_write_i && avs_address_i == 8'h04) begin
            shadow_r <= shadow_r | (avs_writedata_i[11:0] & lanes);
        end else if (done && avs_write_i && avs_address_i == 8'h08) begin
            shadow_r <= shadow_r & ~(avs_writedata_i[11:0] & lanes);
        end
    end
    sequence s_cmp0_armed; compare_zero_hit_i ##1 shadow_r[8]; endsequence
    // Bus timing, decode and read-back
    property p_wait; avs_waitrequest_o && (avs_read_i || avs_write_i)
        |=> !avs_waitrequest_o ##1 avs_waitrequest_o; endproperty
    a_wait: assert property (p_wait) else $error("bus answer timing wrong");
    property p_resp; done |-> avs_response_o ==
        ((avs_address_i inside {8'h00, 8'h04, 8'h08, 8'h0c}) ? 2'h0 : 2'h3); endproperty
    a_resp: assert property (p_resp) else $error("bus response code wrong");
    property p_mask; done && avs_read_i && avs_address_i == 8'h0c
        |-> avs_readdata_o[11:0] == shadow_r; endproperty
    a_mask: assert property (p_mask) else $error("mask read-back wrong");
    property p_wo; done && avs_read_i && avs_address_i inside {8'h04, 8'h08}
        |-> avs_readdata_o == 32'h0; endproperty
    a_wo: assert property (p_wo) else $error("command register reads nonzero");
    property p_upper; done && avs_read_i |-> avs_readdata_o[31:12] == 20'h0; endproperty
    a_upper: assert property (p_upper) else $error("unused bits read nonzero");
    property p_rst; $rose(nrst_i) |-> avs_waitrequest_o && !irq_o; endproperty
    a_rst: assert property (p_rst) else $error("outputs wrong after reset");
    // Interrupt line against the shadow mask
    property p_off; shadow_r == 12'h000 |=> !irq_o; endproperty
    a_off: assert property (p_off) else $error("irq with all sources masked");
    property p_cmp0; s_cmp0_armed |=> irq_o; endproperty
    a_cmp0: assert property (p_cmp0) else $error("compare event gave no irq");
    property p_busy; (shadow_r == 12'h002 && tx_shifter_busy_i) [*2] |=> !irq_o; endproperty
    a_busy: assert property (p_busy) else $error("all-sent irq while busy");
endmodule

// File: sim/spim_irq_mask_tb.sv
// Purpose: Self-checking bench of the serial port interrupt mask block.
// Assumes: Offsets status 0x00, enable 0x04, disable 0x08, mask 0x0c.
// Notes:   One event vector feeds all sources but bits 1 and 5, so a loop walks the other ten bits.
module spim_irq_mask_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic        busy = 1'b1;
    logic        hrd = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  ben = 4'hf;
    logic [11:0] ev = 12'h000;
    logic [31:0] wdat = 32'h0, rdata, q_v;
    logic [1:0]  resp, r_v;
    logic        wreq, irq;
    int          errors = 0;
    int          n_checks = 0;
    // 50 MHz clock
    always #10 clock_i = ~clock_i;
    // Bits 1 and 5 of ev have no pin: those flags are derived inside
    spim_irq_mask #(.ADDR_W(8)) dut_u (
        .clock_i(clock_i), .nrst_i(nrst_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(ben),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .avs_response_o(resp),
        .tx_holding_free_i(ev[0]), .tx_shifter_busy_i(busy), .tx_transfer_end_i(ev[2]),
        .tx_buffers_drained_i(ev[3]), .tx_sync_event_i(ev[10]), .rx_word_load_i(ev[4]),
        .rx_holding_read_i(hrd), .rx_transfer_end_i(ev[6]), .rx_buffers_full_i(ev[7]),
        .rx_sync_event_i(ev[11]), .compare_zero_hit_i(ev[8]), .compare_one_hit_i(ev[9]),
        .irq_o(irq));
    // Word compare; single bits go in zero-extended
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Verdict and end of run
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // One transfer, held until waitrequest is seen low; an idle edge follows.
    // Waitrequest is looked at mid-cycle, where it has settled, so the
    // rising edge that follows is the one that samples it low.
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        int k;
        k = 0;
        wr <= w;
        rd <= !w;
        adr <= a;
        wdat <= d;
        ben <= b;
        do begin
            @(negedge clock_i);
            k++;
        end while (wreq !== 1'b0 && k < 50);
        if (k >= 50) begin
            errors++;
            test_done();
        end
        q_v = rdata;
        r_v = resp;
        @(posedge clock_i);
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0, 4'hf);
        chk(n, e, q_v);
    endtask
    // Reset state, read-only mask, write-only commands, lanes, decode error
    task automatic t_access();
        rdchk("mask rst", 8'h0c, 32'h0);
        acc(1'b1, 8'h0c, 32'hfff, 4'hf);
        rdchk("mask ro", 8'h0c, 32'h0);
        acc(1'b1, 8'h04, 32'hfff, 4'h1);
        rdchk("en rd", 8'h04, 32'h0);
        rdchk("dis rd", 8'h08, 32'h0);
        rdchk("mask lane", 8'h0c, 32'h0ff);
        acc(1'b0, 8'h10, 32'h0, 4'hf);
        chk("rsp", 32'h3, {30'h0, r_v});
        acc(1'b1, 8'h08, 32'hfff, 4'hf);
    endtask
    // Walk every bit through set and clear; high bits must not stick
    task automatic t_walk();
        for (int i = 0; i < 12; i++) begin
            acc(1'b1, 8'h04, 32'h1 << i, 4'hf);
            rdchk("mask set", 8'h0c, (32'h2 << i) - 32'h1);
        end
        acc(1'b1, 8'h04, 32'hffff_f000, 4'hf);
        rdchk("mask high", 8'h0c, 32'h0000_0fff);
        for (int i = 0; i < 12; i++) begin
            acc(1'b1, 8'h08, 32'h1 << i, 4'hf);
            rdchk("mask clr", 8'h0c, 32'hfff & ~((32'h2 << i) - 32'h1));
        end
    endtask
    // Each source but bits 1 and 5 alone: irq, status position, then its clearing
    task automatic t_src();
        for (int i = 0; i < 12; i++) begin
            if (i != 1 && i != 5) begin
                acc(1'b1, 8'h04, 32'h1 << i, 4'hf);
                chk("irq idle", 32'h0, {31'h0, irq});
                ev <= 12'h1 << i;
                @(posedge clock_i);
                ev <= ev & 12'h0cd;
                repeat (2) @(posedge clock_i);
                chk("irq on", 32'h1, {31'h0, irq});
                rdchk("status", 8'h00, 32'h1 << i);
                ev <= 12'h000;
                hrd <= (i == 4);
                @(posedge clock_i);
                hrd <= 1'b0;
                acc(1'b1, 8'h08, 32'h1 << i, 4'hf);
                rdchk("status clr", 8'h00, 32'h0);
            end
        end
    endtask
    // All-sent waits for the shifter; a second unread load flags overrun
    task automatic t_txrx();
        ev <= 12'h001;
        acc(1'b1, 8'h04, 32'h2, 4'hf);
        repeat (2) @(posedge clock_i);
        chk("irq busy", 32'h0, {31'h0, irq});
        busy <= 1'b0;
        repeat (3) @(posedge clock_i);
        chk("irq sent", 32'h1, {31'h0, irq});
        busy <= 1'b1;
        ev <= 12'h010;
        @(posedge clock_i);
        ev <= 12'h000;
        @(posedge clock_i);
        ev <= 12'h010;
        @(posedge clock_i);
        ev <= 12'h000;
        rdchk("overrun", 8'h00, 32'h030);
        rdchk("overrun clr", 8'h00, 32'h010);
    endtask
    // Main sequence: six reset cycles, then the scenarios
    initial begin
        repeat (6) @(posedge clock_i);
        nrst_i <= 1'b1;
        @(posedge clock_i);
        t_access();
        t_walk();
        t_src();
        t_txrx();
        test_done();
    end
endmodule
bind spim_irq_mask spim_irq_mask_checker #(.ADDR_W(ADDR_W)) chk_u (
    .clock_i(clock_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
    .tx_shifter_busy_i(tx_shifter_busy_i), .compare_zero_hit_i(compare_zero_hit_i),
    .irq_o(irq_o));
